// ### verilog/bus_port_consts.svh
// Constants for the instrument bus device port: addresses, command codes and reset values.
`ifndef BUS_PORT_CONSTS_SVH
`define BUS_PORT_CONSTS_SVH
`define ADDR_MAX 5'h1e
`define ADDR_DEFAULT 5'h07
`define CMD_DCL 7'h14
`define CMD_SDC 7'h04
`define CMD_GET 7'h08
`define CMD_UNL 7'h3f
`define CMD_UNT 7'h5f
`define CMD_SPE 7'h18
`define CMD_SPD 7'h19
`define GRP_LISTEN 2'h1
`define GRP_TALK 2'h2
`define FIFO_DEPTH 8
`define FIFO_AW 3
`define TERM_CHAR 8'h0a
`define QUERY_CHAR 8'h3f
`endif

// ### verilog/bus_port_pkg.sv
// Types shared by the instrument bus device port.
package bus_port_pkg;
	// One received bus byte with its end flag.
	typedef struct packed {
		logic eoi;
		logic [7:0] data;
	} bus_byte_t;
	// Acceptor handshake states.
	typedef enum logic [1:0] {
		acc_idle = 2'b00,
		acc_hold = 2'b01,
		acc_done = 2'b11
	} acc_state_t;
endpackage

// ### verilog/byte_fifo.sv
// Small synchronous FIFO with valid and ready on both sides and registered read data.
`timescale 1ns/1ps
module byte_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 8,
	parameter int AW = 3
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic flush,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0] cnt_q;
	logic push;
	logic pop;

	// Output register mirrors the head of the array and adds no storage; the fill count includes it.
	assign in_ready = (cnt_q != (AW+1)'(DEPTH));
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// Storage array write.
	always_ff @(posedge clk) begin
		if (push) begin
			mem_q[wr_q] <= in_data;
		end
	end

	// Pointers and fill count; flush empties everything at once.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else if (flush) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wr_q <= wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= rd_q + 1'b1;
			end
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	// Read data come from a register that tracks the head of the array.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			out_data <= '0;
			out_valid <= 1'b0;
		end else if (flush) begin
			out_valid <= 1'b0;
		end else begin
			if (!out_valid || pop) begin
				if (cnt_q > (AW+1)'(pop)) begin
					out_data <= mem_q[pop ? rd_q + 1'b1 : rd_q];
					out_valid <= 1'b1;
				end else if (push && cnt_q == (AW+1)'(pop)) begin
					out_data <= in_data;
					out_valid <= 1'b1;
				end else begin
					out_valid <= 1'b0;
				end
			end
		end
	end
endmodule

// ### verilog/bus_device_port.sv
// Device side control of an instrument bus port: modes, addressing and bus commands.
// How it works
// - Bytes taken while attention is asserted are decoded as bus commands.
// - Bytes taken while attention is released are device data into the input buffer.
// - The device address is held within 0 to 30 and only it is answered.
// - The address defaults to 7 and changes through a configuration input.
// - Device clear or selected clear flushes the input buffer, clears the query state and resets the parser.
// - A clear during an acquisition also aborts it.
// - Group execute trigger arms the acquisition trigger while addressed as listener.
// - Interface clear unaddresses talker and listener and disables serial poll.
// - At reset the input buffer is empty and the parser at root.
// - talk_ok rises only after a complete valid query message was received; talker is set by the talk address alone.
`timescale 1ns/1ps
`include "bus_port_consts.svh"
module bus_device_port
	import bus_port_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic [7:0] dio_in,
	input wire logic dav_in,
	input wire logic atn_in,
	input wire logic eoi_in,
	input wire logic ifc_in,
	output logic nrfd_out,
	output logic ndac_out,
	output logic nrfd_oe,
	output logic ndac_oe,
	input wire logic [4:0] cfg_addr,
	input wire logic cfg_load,
	input wire logic acq_busy,
	input wire logic resp_ready,
	output logic [8:0] rx_data,
	output logic rx_valid,
	input wire logic rx_ready,
	output logic parser_reset,
	output logic acq_abort,
	output logic trig_arm,
	output logic talker,
	output logic listener,
	output logic spoll_en,
	output logic talk_ok,
	output logic [4:0] my_addr
);
	// Two-stage synchronisers for every bus pin.
	logic [11:0] s1_q;
	logic [11:0] s2_q;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s1_q <= '0;
			s2_q <= '0;
		end else begin
			s1_q <= {dio_in, dav_in, atn_in, eoi_in, ifc_in};
			s2_q <= s1_q;
		end
	end
	logic [7:0] dio;
	logic dav;
	logic atn;
	logic eoi;
	logic ifc;
	assign {dio, dav, atn, eoi, ifc} = s2_q;

	// Address held in range; out-of-range loads are ignored.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			my_addr <= `ADDR_DEFAULT;
		end else if (cfg_load && cfg_addr <= `ADDR_MAX) begin
			my_addr <= cfg_addr;
		end
	end

	// Acceptor handshake: a byte is taken once per data-valid assertion.
	acc_state_t st_q;
	logic fifo_in_ready;
	logic take;
	assign take = (st_q == acc_idle) && dav && (atn || (listener && fifo_in_ready));
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			st_q <= acc_idle;
		end else begin
			unique case (st_q)
				acc_idle: begin
					if (take) begin
						st_q <= acc_hold;
					end
				end
				acc_hold: begin
					st_q <= acc_done;
				end
				acc_done: begin
					if (!dav) begin
						st_q <= acc_idle;
					end
				end
				default: begin
					st_q <= acc_idle;
				end
			endcase
		end
	end

	// Not-ready is held while buffer full or busy; not-accepted until taken.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			nrfd_out <= 1'b0;
			ndac_out <= 1'b0;
			nrfd_oe <= 1'b0;
			ndac_oe <= 1'b0;
		end else begin
			nrfd_oe <= (atn || listener) && (st_q != acc_idle || (!atn && !fifo_in_ready));
			ndac_oe <= (atn || listener) && st_q == acc_idle && !take;
		end
	end

	// Command decode of bytes taken while attention is asserted.
	logic cmd_take;
	logic data_take;
	logic [6:0] cmd;
	logic clear_evt;
	assign cmd_take = take && atn;
	assign data_take = take && !atn;
	assign cmd = dio[6:0];
	assign clear_evt = cmd_take && (cmd == `CMD_DCL || (cmd == `CMD_SDC && listener));

	// Address match on the low five bits of a talk or listen group byte.
	function automatic logic addr_hit(input logic [6:0] c, input logic [1:0] grp, input logic [4:0] a);
		addr_hit = (c[6:5] == grp) && (c[4:0] == a) && (c[4:0] <= `ADDR_MAX);
	endfunction

	// Talker and listener states; interface clear overrides everything.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			talker <= 1'b0;
			listener <= 1'b0;
			spoll_en <= 1'b0;
		end else if (ifc) begin
			talker <= 1'b0;
			listener <= 1'b0;
			spoll_en <= 1'b0;
		end else if (cmd_take) begin
			if (addr_hit(cmd, `GRP_LISTEN, my_addr)) begin
				listener <= 1'b1;
				talker <= 1'b0;
			end else if (addr_hit(cmd, `GRP_TALK, my_addr)) begin
				talker <= 1'b1;
				listener <= 1'b0;
			end else if (cmd[6:5] == `GRP_TALK) begin
				talker <= 1'b0;
			end
			if (cmd == `CMD_UNL) begin
				listener <= 1'b0;
			end
			if (cmd == `CMD_SPE) begin
				spoll_en <= 1'b1;
			end else if (cmd == `CMD_SPD) begin
				spoll_en <= 1'b0;
			end
		end
	end

	// Clear, abort and trigger pulses.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			parser_reset <= 1'b1;
			acq_abort <= 1'b0;
			trig_arm <= 1'b0;
		end else begin
			parser_reset <= clear_evt;
			acq_abort <= clear_evt && acq_busy;
			trig_arm <= cmd_take && cmd == `CMD_GET && listener;
		end
	end

	// Query tracking: a query mark then a terminator makes the message complete.
	logic query_seen_q;
	logic msg_end;
	assign msg_end = data_take && (eoi || dio == `TERM_CHAR);
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			query_seen_q <= 1'b0;
			talk_ok <= 1'b0;
		end else if (clear_evt || ifc) begin
			query_seen_q <= 1'b0;
			talk_ok <= 1'b0;
		end else begin
			if (msg_end) begin
				query_seen_q <= 1'b0;
			end else if (data_take && dio == `QUERY_CHAR) begin
				query_seen_q <= 1'b1;
			end
			if (msg_end && (query_seen_q || dio == `QUERY_CHAR)) begin
				talk_ok <= 1'b1;
			end else if (data_take) begin
				talk_ok <= 1'b0;
			end else begin
				talk_ok <= talk_ok && !(talker && resp_ready) ? talk_ok : talk_ok;
			end
		end
	end

	// Input buffer of device data; flushed by a clear.
	bus_byte_t in_byte;
	assign in_byte = '{eoi: eoi, data: dio};
	byte_fifo #(
		.WIDTH(9),
		.DEPTH(`FIFO_DEPTH),
		.AW(`FIFO_AW)
	) u_in_buf (
		.clk(clk),
		.resetn(resetn),
		.flush(clear_evt),
		.in_data(in_byte),
		.in_valid(data_take),
		.in_ready(fifo_in_ready),
		.out_data(rx_data),
		.out_valid(rx_valid),
		.out_ready(rx_ready)
	);
endmodule

// ### tb/bus_port_properties.sv
// Checker on the ports of the bus device port.
`timescale 1ns/1ps
module bus_port_props (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [4:0] cfg_addr,
	input wire logic cfg_load,
	input wire logic parser_reset,
	input wire logic acq_abort,
	input wire logic trig_arm,
	input wire logic ifc_in,
	input wire logic talker,
	input wire logic listener,
	input wire logic spoll_en,
	input wire logic talk_ok,
	input wire logic [4:0] my_addr
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	// Address range, loading and the effects of bus commands.
	addr_range_a: assert property (my_addr <= 5'h1e) else $error("address out of range");
	addr_load_a: assert property (cfg_load && cfg_addr <= 5'h1e |=> my_addr == $past(cfg_addr))
		else $error("address not loaded");
	addr_keep_a: assert property (cfg_load && cfg_addr > 5'h1e |=> $stable(my_addr))
		else $error("bad address taken");
	ifc_idle_a: assert property (ifc_in |-> ##[1:4] !(talker || listener || spoll_en))
		else $error("interface clear ignored");
	abort_clear_a: assert property (acq_abort |-> parser_reset) else $error("abort without clear");
	trig_pulse_a: assert property (trig_arm |=> !trig_arm) else $error("trigger pulse too long");
	role_excl_a: assert property (!(talker && listener)) else $error("talker and listener at once");
	clear_query_a: assert property ($rose(parser_reset) |=> !talk_ok) else $error("query kept on clear");
endmodule
bind bus_device_port bus_port_props u_props (.*);

// ### tb/bus_host_model.sv
// Behavioural bus controller that sources command and data bytes.
`timescale 1ns/1ps
module bus_host_model (
	input wire logic clk,
	input wire logic nrfd_oe,
	input wire logic ndac_oe,
	output logic [7:0] dio,
	output logic dav,
	output logic atn,
	output logic eoi,
	output logic ifc
);
	int n;
	// Idle bus at time zero.
	initial begin
		dio = 8'h00;
		dav = 1'b0;
		atn = 1'b0;
		eoi = 1'b0;
		ifc = 1'b0;
	end
	// Sources one byte and holds it until accepted; ok is low if the device never answers.
	task automatic send(input logic [7:0] b, input logic a, input logic e, output logic ok);
		n = 0;
		@(posedge clk);
		#1;
		while (!a && nrfd_oe && n < 60) begin
			@(posedge clk);
			#1;
			n++;
		end
		ok = (n < 60);
		atn = a;
		eoi = e;
		dio = b;
		if (!ok) return;
		@(posedge clk);
		#1;
		dav = 1'b1;
		n = 0;
		// The pins pass two flip-flops, so a low not-accepted alone proves nothing.
		// A byte counts as taken once the device holds not-ready and has released not-accepted.
		while (!(nrfd_oe && !ndac_oe) && n < 20) begin
			@(posedge clk);
			#1;
			n++;
		end
		ok = (n < 20);
		dav = 1'b0;
		eoi = 1'b0;
		dio = ~b; // Released lines do not keep the last value.
	endtask
	// Holds interface clear for five cycles.
	task automatic clear_bus();
		@(posedge clk);
		#1;
		ifc = 1'b1;
		repeat (5) @(posedge clk);
		#1;
		ifc = 1'b0;
	endtask
endmodule

// ### tb/bus_device_port_tb.sv
// Self-checking bench for the bus device port.
`timescale 1ns/1ps
`include "bus_port_consts.svh"
module bus_device_port_tb;
	logic clk = 1'b0, resetn = 1'b0, cfg_load = 1'b0, acq_busy = 1'b0, rx_ready = 1'b1, resp_ready = 1'b0;
	logic [4:0] cfg_addr = 5'h00;
	logic [7:0] dio_in;
	logic dav_in, atn_in, eoi_in, ifc_in, nrfd_out, ndac_out, nrfd_oe, ndac_oe, rx_valid, parser_reset;
	logic acq_abort, trig_arm, talker, listener, spoll_en, talk_ok, pr, ab, tr, ok;
	logic [8:0] rx_data, last_rx;
	logic [4:0] my_addr;
	int fail_count = 0, n_compared = 0;
	bus_device_port uut (.*);
	bus_host_model host (.clk(clk), .nrfd_oe(nrfd_oe), .ndac_oe(ndac_oe), .dio(dio_in), .dav(dav_in),
		.atn(atn_in), .eoi(eoi_in), .ifc(ifc_in));
	always #20 clk = ~clk;
	// Catches one-cycle pulses and the last byte read from the buffer.
	always @(posedge clk) begin
		if (parser_reset) pr <= 1'b1;
		if (acq_abort) ab <= 1'b1;
		if (trig_arm) tr <= 1'b1;
		if (rx_valid && rx_ready) last_rx <= rx_data;
	end
	task automatic check(input string what, input logic [8:0] got, input logic [8:0] exp);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic report_and_stop();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// Sends a byte, judges acceptance and lets its effects land.
	task automatic xfer(input logic [7:0] v, input logic a, input logic e, input logic exp_ok);
		{pr, ab, tr} = 3'b000;
		host.send(v, a, e, ok);
		check("accepted", ok, exp_ok);
		repeat (3) @(posedge clk);
		#1;
	endtask
	task automatic load_addr(input logic [4:0] v, input logic [4:0] exp);
		cfg_addr = v;
		cfg_load = 1'b1;
		@(posedge clk);
		#1;
		cfg_load = 1'b0;
		@(posedge clk);
		#1;
		check("my_addr", my_addr, exp);
	endtask
	// Looks at the outputs while reset is still held.
	task automatic t_reset();
		check("reset clear", parser_reset, 1'b1);
		check("reset rx", rx_valid, 1'b0);
		check("reset addr", my_addr, 9'h007);
	endtask
	task automatic t_addr();
		check("start addr", my_addr, 9'h007);
		check("pull levels", {nrfd_out, ndac_out}, 9'h000);
		check("start rx", rx_valid, 1'b0);
		check("start clear", parser_reset, 1'b0);
		load_addr(5'h1f, 5'h07);
		load_addr(5'h1e, 5'h1e);
		load_addr(5'h07, 5'h07);
	endtask
	task automatic t_listen();
		xfer(8'h28, 1'b1, 1'b0, 1'b1);
		check("other listen", listener, 1'b0);
		xfer(8'h27, 1'b1, 1'b0, 1'b1);
		check("my listen", listener, 1'b1);
		xfer(8'h41, 1'b0, 1'b1, 1'b1);
		check("rx byte", last_rx, 9'h141);
		xfer(8'(`CMD_UNL), 1'b1, 1'b0, 1'b1);
		check("unlisten", listener, 1'b0);
		xfer(8'h42, 1'b0, 1'b0, 1'b0);
	endtask
	task automatic t_clear();
		xfer(8'h27, 1'b1, 1'b0, 1'b1);
		rx_ready = 1'b0;
		for (int i = 0; i < 8; i++) xfer(8'h30 + i[7:0], 1'b0, 1'b0, 1'b1);
		xfer(8'h55, 1'b0, 1'b0, 1'b0);
		acq_busy = 1'b1;
		xfer(8'(`CMD_SDC), 1'b1, 1'b0, 1'b1);
		check("sdc clear", pr, 1'b1);
		check("sdc abort", ab, 1'b1);
		check("flushed", rx_valid, 1'b0);
		acq_busy = 1'b0;
		rx_ready = 1'b1;
		xfer(8'(`CMD_DCL), 1'b1, 1'b0, 1'b1);
		check("dcl clear", pr, 1'b1);
		check("idle abort", ab, 1'b0);
		xfer(8'(`CMD_GET), 1'b1, 1'b0, 1'b1);
		check("trigger", tr, 1'b1);
	endtask
	task automatic t_query();
		xfer(`QUERY_CHAR, 1'b0, 1'b0, 1'b1);
		xfer(`TERM_CHAR, 1'b0, 1'b0, 1'b1);
		check("query done", talk_ok, 1'b1);
		xfer(8'h47, 1'b1, 1'b0, 1'b1);
		check("talker", talker, 1'b1);
		check("unlistened", listener, 1'b0);
		xfer(8'(`CMD_SPE), 1'b1, 1'b0, 1'b1);
		check("poll on", spoll_en, 1'b1);
		xfer(8'(`CMD_SPD), 1'b1, 1'b0, 1'b1);
		check("poll off", spoll_en, 1'b0);
		xfer(8'(`CMD_SPE), 1'b1, 1'b0, 1'b1);
		check("poll again", spoll_en, 1'b1);
		host.clear_bus();
		repeat (4) @(posedge clk);
		#1;
		check("ifc roles", {talker, listener, spoll_en}, 3'b000);
		check("ifc query", talk_ok, 1'b0);
	endtask
	// Main sequence after twelve cycles of reset.
	initial begin
		repeat (12) @(posedge clk);
		#1;
		t_reset();
		resetn = 1'b1;
		repeat (2) @(posedge clk);
		#1;
		t_addr();
		t_listen();
		t_clear();
		t_query();
		report_and_stop();
	end
	// Watchdog against a hung handshake.
	initial begin
		#400000;
		fail_count++;
		report_and_stop();
	end
endmodule
